// [rtl/rim_mask_top.sv]
// mask registers and interrupt flag gating for two converters and two linear regulators
`timescale 1ns/1ns
`default_nettype none
module rim_mask_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire rim_pkg::rim_bus_req_t busReq,
   input wire logic [7:0] rdAddr,
   input wire logic otpResetRegMask,
   input wire logic resetRegEvent,
   input wire logic resetRegClear,
   input wire rim_pkg::rim_raw_t conv0Raw,
   input wire rim_pkg::rim_raw_t conv1Raw,
   input wire rim_pkg::rim_raw_t linreg0Raw,
   input wire rim_pkg::rim_raw_t linreg1Raw,
   input wire logic [3:0] pgFlagClear,
   input wire logic [3:0] ilimFlagClear,
   output logic [7:0] rdData,
   output logic resetRegIrqFlag,
   output logic conv0_pg_irq_flag,
   output logic conv1_pg_irq_flag,
   output logic conv0_current_limit_irq_flag,
   output logic conv1_current_limit_irq_flag,
   output logic linreg0_pg_irq_flag,
   output logic linreg1_pg_irq_flag,
   output logic linreg0_current_limit_irq_flag,
   output logic linreg1_current_limit_irq_flag,
   output logic [7:0] rawStatusConv,
   output logic [7:0] rawStatusLinreg
);
   logic [7:0] convMask_q, convMask_d, linregMask_q, linregMask_d;
   logic resetMask_q, resetMask_d, resetFlag_q, resetFlag_d, otpLoad_q, otpLoad_d;
   logic [7:0] rdData_q, rdData_d, rawConv_q, rawConv_d, rawLin_q, rawLin_d;
   logic [3:0] pgFlagW, ilimFlagW;

   // merge a write into a mask register, reserved bits keep their old value
   function automatic logic [7:0] merge_write(input logic [7:0] oldVal, input logic [7:0] wr,
                                              input logic [7:0] writable);
      merge_write = (wr & writable) | (oldVal & ~writable);
   endfunction

   // pack raw status of two units into the status layout
   function automatic logic [7:0] pack_raw(input rim_pkg::rim_raw_t u1,
                                           input rim_pkg::rim_raw_t u0);
      pack_raw = 8'h00;
      pack_raw[rim_pkg::POS_UNIT1_PG_VALID] = u1.pgRaw; // 1 = invalid
      pack_raw[rim_pkg::POS_UNIT1_CURRENT_LIMIT] = u1.currentLimitRaw;
      pack_raw[rim_pkg::POS_UNIT0_PG_VALID] = u0.pgRaw;
      pack_raw[rim_pkg::POS_UNIT0_CURRENT_LIMIT] = u0.currentLimitRaw;
   endfunction

   // ==========================================================
   // mask registers and reset-interrupt mask
   always_comb begin
      convMask_d = convMask_q;
      linregMask_d = linregMask_q;
      resetMask_d = resetMask_q;
      otpLoad_d = 1'b0;
      if (otpLoad_q) begin
         resetMask_d = otpResetRegMask; // reload from OTP after reset
      end
      if (busReq.wrEn) begin
         unique case (busReq.addr)
            rim_pkg::ADDR_CONV_MASK: begin
               convMask_d = merge_write(convMask_q, busReq.wrData,
                                        rim_pkg::GROUP_MASK_WRITABLE);
            end
            rim_pkg::ADDR_LINREG_MASK: begin
               linregMask_d = merge_write(linregMask_q, busReq.wrData,
                                          rim_pkg::GROUP_MASK_WRITABLE);
            end
            rim_pkg::ADDR_TOP_MASK_TWO: begin
               resetMask_d = busReq.wrData[rim_pkg::POS_RESET_REG_MASK];
            end
            default: begin
            end
         endcase
      end
   end

   // reset event flag and read mux
   always_comb begin
      resetFlag_d = resetFlag_q && !resetRegClear;
      if (resetRegEvent && !resetMask_q) begin
         resetFlag_d = 1'b1;
      end
      rawConv_d = pack_raw(conv1Raw, conv0Raw); // unmasked live state
      rawLin_d = pack_raw(linreg1Raw, linreg0Raw);
      unique case (rdAddr)
         rim_pkg::ADDR_CONV_MASK: rdData_d = convMask_q;
         rim_pkg::ADDR_LINREG_MASK: rdData_d = linregMask_q;
         rim_pkg::ADDR_TOP_MASK_TWO: rdData_d = {7'h00, resetMask_q};
         default: rdData_d = 8'h00;
      endcase
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         convMask_q <= rim_pkg::RESET_MASK_VALUE;
         linregMask_q <= rim_pkg::RESET_MASK_VALUE;
         resetMask_q <= 1'b0;
         resetFlag_q <= 1'b0;
         otpLoad_q <= 1'b1;
         rdData_q <= 8'h00;
         rawConv_q <= 8'h00;
         rawLin_q <= 8'h00;
      end else begin
         convMask_q <= convMask_d;
         linregMask_q <= linregMask_d;
         resetMask_q <= resetMask_d;
         resetFlag_q <= resetFlag_d;
         otpLoad_q <= otpLoad_d;
         rdData_q <= rdData_d;
         rawConv_q <= rawConv_d;
         rawLin_q <= rawLin_d;
      end
   end

   // ==========================================================
   // per-unit flag logic: converters use bits 7/6/4 and 3/2/0
   rim_unit_flags uConv0 (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(conv0Raw),
      .pgInvalidMask(convMask_q[rim_pkg::POS_UNIT0_PG_INVALID]),
      .pgValidMask(convMask_q[rim_pkg::POS_UNIT0_PG_VALID]),
      .currentLimitMask(convMask_q[rim_pkg::POS_UNIT0_CURRENT_LIMIT]),
      .pgClear(pgFlagClear[0]), .ilimClear(ilimFlagClear[0]),
      .pgFlag(pgFlagW[0]), .ilimFlag(ilimFlagW[0])
   );
   rim_unit_flags uConv1 (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(conv1Raw),
      .pgInvalidMask(convMask_q[rim_pkg::POS_UNIT1_PG_INVALID]),
      .pgValidMask(convMask_q[rim_pkg::POS_UNIT1_PG_VALID]),
      .currentLimitMask(convMask_q[rim_pkg::POS_UNIT1_CURRENT_LIMIT]),
      .pgClear(pgFlagClear[1]), .ilimClear(ilimFlagClear[1]),
      .pgFlag(pgFlagW[1]), .ilimFlag(ilimFlagW[1])
   );
   rim_unit_flags uLinreg0 (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(linreg0Raw),
      .pgInvalidMask(linregMask_q[rim_pkg::POS_UNIT0_PG_INVALID]),
      .pgValidMask(linregMask_q[rim_pkg::POS_UNIT0_PG_VALID]),
      .currentLimitMask(linregMask_q[rim_pkg::POS_UNIT0_CURRENT_LIMIT]),
      .pgClear(pgFlagClear[2]), .ilimClear(ilimFlagClear[2]),
      .pgFlag(pgFlagW[2]), .ilimFlag(ilimFlagW[2])
   );
   rim_unit_flags uLinreg1 (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(linreg1Raw),
      .pgInvalidMask(linregMask_q[rim_pkg::POS_UNIT1_PG_INVALID]),
      .pgValidMask(linregMask_q[rim_pkg::POS_UNIT1_PG_VALID]),
      .currentLimitMask(linregMask_q[rim_pkg::POS_UNIT1_CURRENT_LIMIT]),
      .pgClear(pgFlagClear[3]), .ilimClear(ilimFlagClear[3]),
      .pgFlag(pgFlagW[3]), .ilimFlag(ilimFlagW[3])
   );

   // outputs from flip-flops
   assign rdData = rdData_q;
   assign resetRegIrqFlag = resetFlag_q;
   assign conv0_pg_irq_flag = pgFlagW[0];
   assign conv1_pg_irq_flag = pgFlagW[1];
   assign linreg0_pg_irq_flag = pgFlagW[2];
   assign linreg1_pg_irq_flag = pgFlagW[3];
   assign conv0_current_limit_irq_flag = ilimFlagW[0];
   assign conv1_current_limit_irq_flag = ilimFlagW[1];
   assign linreg0_current_limit_irq_flag = ilimFlagW[2];
   assign linreg1_current_limit_irq_flag = ilimFlagW[3];
   assign rawStatusConv = rawConv_q;
   assign rawStatusLinreg = rawLin_q;
endmodule
`default_nettype wire

// [inc/rim_pkg.sv]
// package of register map, field positions and carrier types for the regulator mask block
`default_nettype none
package rim_pkg;
   // ==========================================================
   // register addresses
   localparam logic [7:0] ADDR_TOP_MASK_TWO = 8'h21;
   localparam logic [7:0] ADDR_CONV_MASK = 8'h22;
   localparam logic [7:0] ADDR_LINREG_MASK = 8'h23;
   // ==========================================================
   // field positions inside the converter, regulator and top mask two registers
   localparam int POS_UNIT1_PG_INVALID = 7;
   localparam int POS_UNIT1_PG_VALID = 6;
   localparam int POS_UNIT1_CURRENT_LIMIT = 4;
   localparam int POS_UNIT0_PG_INVALID = 3;
   localparam int POS_UNIT0_PG_VALID = 2;
   localparam int POS_UNIT0_CURRENT_LIMIT = 0;
   localparam int POS_RESET_REG_MASK = 0;
   // writable bits; bits 5 and 1 are reserved and read zero
   localparam logic [7:0] GROUP_MASK_WRITABLE = 8'hDD;
   localparam logic [7:0] TOP_TWO_WRITABLE = 8'h01;
   // ==========================================================
   // values after reset
   localparam logic [7:0] RESET_MASK_VALUE = 8'h00;
   localparam logic [1:0] RESET_FLAGS = 2'h0;
   // ==========================================================
   // live condition of one regulator
   typedef struct packed {
      logic pgRaw;           // 1 while output voltage is invalid
      logic currentLimitRaw; // 1 while current limit is active
   } rim_raw_t;
   // register bus request
   typedef struct packed {
      logic wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } rim_bus_req_t;
endpackage
`default_nettype wire

// [rtl/rim_unit_flags.sv]
// event detection and sticky interrupt flags for one regulator
`timescale 1ns/1ns
`default_nettype none
module rim_unit_flags (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire rim_pkg::rim_raw_t raw,
   input wire logic pgInvalidMask,
   input wire logic pgValidMask,
   input wire logic currentLimitMask,
   input wire logic pgClear,
   input wire logic ilimClear,
   output logic pgFlag,
   output logic ilimFlag
);
   logic pgPrev_q, pgPrev_d, ilimPrev_q, ilimPrev_d;
   logic pgFlag_q, pgFlag_d, ilimFlag_q, ilimFlag_d;
   logic pgInvalidEvt, pgValidEvt, ilimEvt;

   // ==========================================================
   // next state: edges of raw status, masked, set over clear
   always_comb begin
      pgPrev_d = raw.pgRaw;
      ilimPrev_d = raw.currentLimitRaw;
      pgInvalidEvt = raw.pgRaw && !pgPrev_q;
      pgValidEvt = !raw.pgRaw && pgPrev_q;
      ilimEvt = raw.currentLimitRaw && !ilimPrev_q;
      pgFlag_d = pgFlag_q && !pgClear; // mask setting never clears a flag
      if ((pgInvalidEvt && !pgInvalidMask) || (pgValidEvt && !pgValidMask)) begin
         pgFlag_d = 1'b1;
      end
      ilimFlag_d = ilimFlag_q && !ilimClear;
      if (ilimEvt && !currentLimitMask) begin
         ilimFlag_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pgPrev_q <= 1'b0;
         ilimPrev_q <= 1'b0;
         pgFlag_q <= 1'b0;
         ilimFlag_q <= 1'b0;
      end else begin
         pgPrev_q <= pgPrev_d;
         ilimPrev_q <= ilimPrev_d;
         pgFlag_q <= pgFlag_d;
         ilimFlag_q <= ilimFlag_d;
      end
   end

   assign pgFlag = pgFlag_q;
   assign ilimFlag = ilimFlag_q;
endmodule
`default_nettype wire

// [sim/rim_mask_props.sv]
// checker of mask gating, raw status and register reads
`timescale 1ns/1ns
`default_nettype none
module rim_mask_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire rim_pkg::rim_bus_req_t busReq,
   input wire logic [7:0] rdAddr,
   input wire logic otpResetRegMask,
   input wire logic resetRegEvent,
   input wire rim_pkg::rim_raw_t conv0Raw,
   input wire rim_pkg::rim_raw_t conv1Raw,
   input wire logic [3:0] pgFlagClear,
   input wire logic [7:0] rdData,
   input wire logic resetRegIrqFlag,
   input wire logic conv0_pg_irq_flag,
   input wire logic conv1_pg_irq_flag,
   input wire logic conv0_current_limit_irq_flag,
   input wire logic conv1_current_limit_irq_flag,
   input wire logic [7:0] rawStatusConv
);
   logic [7:0] convMask_q;
   logic rstMask_q;
   logic first_q;
   // mirror of the masks, the otp copy lands on the first edge after reset
   always_ff @(posedge sys_clk) begin
      first_q <= sys_rst;
      if (sys_rst) begin
         convMask_q <= 8'h00;
         rstMask_q <= 1'b0;
      end else begin
         if (busReq.wrEn && busReq.addr == 8'h22) begin
            convMask_q <= busReq.wrData & 8'hDD;
         end
         if (busReq.wrEn && busReq.addr == 8'h21) begin
            rstMask_q <= busReq.wrData[0];
         end else if (first_q) begin
            rstMask_q <= otpResetRegMask;
         end
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_raw_conv_track: assert property (!$past(sys_rst) |->
      rawStatusConv == {1'b0, $past(conv1Raw.pgRaw), 1'b0, $past(conv1Raw.currentLimitRaw),
      1'b0, $past(conv0Raw.pgRaw), 1'b0, $past(conv0Raw.currentLimitRaw)}) else $error("raw");
   a_ilim0_gate: assert property (
      $rose(conv0Raw.currentLimitRaw) && !convMask_q[0] |=> conv0_current_limit_irq_flag)
      else $error("ilim0 lost");
   a_ilim1_masked: assert property ($rose(conv1Raw.currentLimitRaw) && convMask_q[4]
      && !conv1_current_limit_irq_flag |=> !conv1_current_limit_irq_flag) else $error("ilim1");
   a_pg1_invalid: assert property (
      $rose(conv1Raw.pgRaw) && !convMask_q[7] |=> conv1_pg_irq_flag) else $error("pg1");
   a_pg0_valid_masked: assert property ($fell(conv0Raw.pgRaw) && convMask_q[2]
      && !conv0_pg_irq_flag |=> !conv0_pg_irq_flag) else $error("pg0 valid");
   a_flag_sticky: assert property (
      conv1_pg_irq_flag && !pgFlagClear[1] |=> conv1_pg_irq_flag) else $error("sticky");
   a_rst_flag_gate: assert property (
      resetRegEvent && !rstMask_q && !first_q |=> resetRegIrqFlag) else $error("rst flag");
   a_rst_mask_read: assert property (rdAddr == 8'h21 && !busReq.wrEn && !first_q
      |=> rdData == {7'h00, rstMask_q}) else $error("rst mask read");
   a_conv_read: assert property (
      rdAddr == 8'h22 && !busReq.wrEn |=> rdData == convMask_q) else $error("conv read");
   a_unmapped_read: assert property (
      rdAddr > 8'h23 |=> rdData == 8'h00) else $error("unmapped");
endmodule
bind rim_mask_top rim_mask_props props_u (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq), .rdAddr(rdAddr),
   .otpResetRegMask(otpResetRegMask), .resetRegEvent(resetRegEvent),
   .conv0Raw(conv0Raw), .conv1Raw(conv1Raw), .pgFlagClear(pgFlagClear), .rdData(rdData),
   .resetRegIrqFlag(resetRegIrqFlag), .conv0_pg_irq_flag(conv0_pg_irq_flag),
   .conv1_pg_irq_flag(conv1_pg_irq_flag),
   .conv0_current_limit_irq_flag(conv0_current_limit_irq_flag),
   .conv1_current_limit_irq_flag(conv1_current_limit_irq_flag),
   .rawStatusConv(rawStatusConv)
);
`default_nettype wire

// [sim/rim_host_model.sv]
// host side register master driving writes and read addresses
`timescale 1ns/1ns
`default_nettype none
module rim_host_model (
   input wire logic sys_clk,
   output var rim_pkg::rim_bus_req_t busReq,
   output logic [7:0] rdAddr,
   input wire logic [7:0] rdData
);
   // idle lines at time zero
   initial begin
      busReq = '0;
      rdAddr = 8'h00;
   end
   // single write strobe, then park the lines on inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      busReq = '{1'b1, a, d};
      @(negedge sys_clk);
      busReq = '{1'b0, ~a, ~d};
   endtask
   // read: address held until the registered answer has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      rdAddr = a;
      @(negedge sys_clk);
      d = rdData;
   endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the regulator mask block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic sys_clk, sys_rst, otpMask, rstEvent, rstClear;
   rim_pkg::rim_bus_req_t busReq;
   logic [7:0] rdAddr, rdData, rawConv, rawLin, got, mk, a;
   rim_pkg::rim_raw_t raws [4];
   logic [3:0] pgClr, ilimClr;
   wire logic [7:0] flags;
   wire logic rstFlag;
   logic [31:0] seed = 32'h9881;
   int bad_count = 0;
   int tests_run = 0;
   rim_host_model host_u (.sys_clk(sys_clk), .busReq(busReq), .rdAddr(rdAddr), .rdData(rdData));
   rim_mask_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq), .rdAddr(rdAddr),
      .otpResetRegMask(otpMask), .resetRegEvent(rstEvent), .resetRegClear(rstClear),
      .conv0Raw(raws[0]), .conv1Raw(raws[1]), .linreg0Raw(raws[2]), .linreg1Raw(raws[3]),
      .pgFlagClear(pgClr), .ilimFlagClear(ilimClr), .rdData(rdData), .resetRegIrqFlag(rstFlag),
      .conv0_pg_irq_flag(flags[0]), .conv1_pg_irq_flag(flags[1]),
      .linreg0_pg_irq_flag(flags[2]), .linreg1_pg_irq_flag(flags[3]),
      .conv0_current_limit_irq_flag(flags[4]), .conv1_current_limit_irq_flag(flags[5]),
      .linreg0_current_limit_irq_flag(flags[6]), .linreg1_current_limit_irq_flag(flags[7]),
      .rawStatusConv(rawConv), .rawStatusLinreg(rawLin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rawExp(input rim_pkg::rim_raw_t r1, input rim_pkg::rim_raw_t r0);
      return {1'b0, r1.pgRaw, 1'b0, r1.currentLimitRaw, 1'b0, r0.pgRaw, 1'b0, r0.currentLimitRaw};
   endfunction
   function automatic logic [7:0] regExp(input logic [7:0] ad, input logic [7:0] d);
      if (ad == 8'h21) return d & 8'h01;
      if (ad == 8'h22 || ad == 8'h23) return d & 8'hDD;
      return 8'h00;
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic do_reset(input logic otp);
      @(negedge sys_clk);
      otpMask = otp;
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
   endtask
   // wait two cycles, then check a flag and both raw status bytes
   task automatic settle(input int idx, input logic e);
      tick(2);
      chk({7'h00, flags[idx]}, {7'h00, e});
      chk(rawConv, rawExp(raws[1], raws[0]));
      chk(rawLin, rawExp(raws[3], raws[2]));
   endtask
   task automatic clr(input int u);
      pgClr = 4'h1 << u;
      ilimClr = 4'h1 << u;
      tick(1);
      pgClr = 4'h0;
      ilimClr = 4'h0;
   endtask
   task automatic ev_rst(input logic e);
      rstEvent = 1'b1;
      tick(1);
      rstEvent = 1'b0;
      tick(1);
      chk({7'h00, rstFlag}, {7'h00, e});
      rstClear = 1'b1;
      tick(1);
      rstClear = 1'b0;
   endtask
   // invalid, valid and current-limit events of one unit under mask m
   task automatic unit_run(input int u, input logic [7:0] m);
      int h;
      h = 4 * (u % 2);
      a = (u < 2) ? rim_pkg::ADDR_CONV_MASK : rim_pkg::ADDR_LINREG_MASK;
      host_u.wr(a, m);
      raws[u].pgRaw = 1'b1;
      settle(u, !m[h + 3]);
      clr(u);
      raws[u].pgRaw = 1'b0;
      settle(u, !m[h + 2]);
      clr(u);
      raws[u].currentLimitRaw = 1'b1;
      settle(u + 4, !m[h]);
      host_u.wr(a, 8'hFF);
      chk({7'h00, flags[u + 4]}, {7'h00, !m[h]});
      raws[u].currentLimitRaw = 1'b0;
      clr(u);
   endtask
   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // cut a hang short after far more than the sequence needs
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   // main sequence
   initial begin
      {sys_rst, otpMask, rstEvent, rstClear, pgClr, ilimClr} = 12'h800;
      foreach (raws[i]) raws[i] = '0;
      do_reset(1'b1);
      host_u.rd(rim_pkg::ADDR_TOP_MASK_TWO, got);
      chk(got, 8'h01);
      ev_rst(1'b0);
      host_u.wr(rim_pkg::ADDR_TOP_MASK_TWO, 8'hFE);
      ev_rst(1'b1);
      do_reset(1'b1);
      host_u.rd(rim_pkg::ADDR_TOP_MASK_TWO, got);
      chk(got, 8'h01);
      // a cleared otp copy must reload as zero over the set mask
      do_reset(1'b0);
      host_u.rd(rim_pkg::ADDR_TOP_MASK_TWO, got);
      chk(got, 8'h00);
      $display("test reset mask done");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         a = 8'h21 + 8'(i % 4);
         host_u.wr(a, seed[7:0]);
         host_u.rd(a, got);
         chk(got, regExp(a, seed[7:0]));
      end
      $display("test registers done");
      for (int u = 0; u < 4; u++) begin
         for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            mk = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
            unit_run(u, mk);
         end
      end
      $display("test event gating done");
      summarize();
   end
endmodule
`default_nettype wire
